//--- shared/port_pin_consts.svh
// register offsets, field positions and reset values of the port pin block
`ifndef PORT_PIN_CONSTS_SVH
`define PORT_PIN_CONSTS_SVH

`define OFS_OUT_VALUE    8'h00
`define OFS_PIN_STATE    8'h04
`define OFS_DRV_LOW      8'h08
`define OFS_DRV_MID      8'h0c
`define OFS_DRV_HIGH     8'h10
`define OFS_BYPASS       8'h14
`define OFS_DSYNC        8'h18
`define OFS_SLOW         8'h1c
`define OFS_BIDIR        8'h20
`define OFS_EVT_FLAGS    8'h24
`define OFS_EVT_MASK     8'h28
`define OFS_EDGE_SEL     8'h2c
`define OFS_OE_SEL       8'h30
`define OFS_RST_STATE    8'h38
`define PIN_FORM_TAG     2'h1

`define PF_MODE_LSB      0
`define PF_OUT           3
`define PF_BYP           4
`define PF_SLOW          5
`define PF_BIDIR         6
`define PF_DSYNC         7
`define PF_EDGE_LSB      8

`define RST_STATE_INIT   32'h0000_0000
`define MODE_RESET       3'h0

`endif

//--- shared/port_pin_pkg.sv
// types shared by the port pin block
package port_pin_pkg;
  typedef logic [2:0] drive_mode_bits_t;
  typedef enum logic [2:0] {
    MODE_HIZ_ANALOG, MODE_HIZ_DIGITAL, MODE_RES_UP, MODE_RES_DOWN,
    MODE_OD_LOW, MODE_OD_HIGH, MODE_STRONG, MODE_RES_BOTH
  } drive_mode_e;
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} pin_edge_select_e;
endpackage : port_pin_pkg

//--- shared/drive_if.sv
// carrier between port control and the drive decoder
`timescale 1ns/100ps
interface drive_if #(parameter int PINS = 8);
  logic [PINS-1:0][2:0] mode;
  logic [PINS-1:0] data;
  logic [PINS-1:0] drv_en;
  logic [PINS-1:0] drv_val;
  logic [PINS-1:0] res;
  logic [PINS-1:0] inbuf_en;
  modport ctrl (output mode, output data, input drv_en, input drv_val, input res,
    input inbuf_en);
  modport dec (input mode, input data, output drv_en, output drv_val, output res,
    output inbuf_en);
endinterface : drive_if

//--- hw/drive_decode.sv
// per-pin drive mode decoder
`timescale 1ns/100ps
module drive_decode
  import port_pin_pkg::*;
#(
  parameter int PINS = 8
) (
  drive_if.dec dif
);
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      dif.drv_en[i] = 1'b0;
      dif.drv_val[i] = dif.data[i];
      dif.res[i] = 1'b0;
      dif.inbuf_en[i] = 1'b1;
      case (drive_mode_e'(dif.mode[i]))
        MODE_HIZ_ANALOG: begin
          dif.inbuf_en[i] = 1'b0;
        end
        MODE_HIZ_DIGITAL: begin
          dif.drv_en[i] = 1'b0;
        end
        MODE_RES_UP: begin
          dif.drv_en[i] = 1'b1;
          dif.res[i] = dif.data[i];
        end
        MODE_RES_DOWN: begin
          dif.drv_en[i] = 1'b1;
          dif.res[i] = ~dif.data[i];
        end
        MODE_OD_LOW: begin
          dif.drv_en[i] = ~dif.data[i];
        end
        MODE_OD_HIGH: begin
          dif.drv_en[i] = dif.data[i];
        end
        MODE_STRONG: begin
          dif.drv_en[i] = 1'b1;
        end
        MODE_RES_BOTH: begin
          dif.drv_en[i] = 1'b1;
          dif.res[i] = 1'b1;
        end
        default: begin
          dif.inbuf_en[i] = 1'b0;
        end
      endcase
    end
  end
endmodule : drive_decode

//--- hw/port_pin_drive_control.sv
// port of general purpose pins: drive modes, pin state, edge events
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "port_pin_consts.svh"
module port_pin_drive_control
  import port_pin_pkg::*;
#(
  parameter int PINS = 8,
  parameter int AUX_OE = 16
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // pins
  input wire logic [PINS-1:0] pin_i,
  output logic [PINS-1:0] pin_o,
  output logic [PINS-1:0] pin_oe_o,
  output logic [PINS-1:0] pin_res_o,
  output logic [PINS-1:0] pin_slow_o,
  output logic [PINS-1:0] pin_inbuf_en_o,
  // routed digital signals
  input wire logic [PINS-1:0] sys_out_i,
  input wire logic [AUX_OE-1:0] aux_oe_i,
  output logic [PINS-1:0] sys_in_o,
  // interrupt
  output logic irq_o
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (PINS < 1 || PINS > 8 || AUX_OE < 1 || AUX_OE > 16) begin : g_bad_param
    $error("PINS must be 1 to 8 and AUX_OE 1 to 16");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [PINS-1:0] port_output_value, output_bypass_select, input_double_sync;
  logic [PINS-1:0] slow_edge_select, bidir_enable, pin_event_flags, event_mask;
  drive_mode_bits_t drive_mode_bits [PINS];
  logic [1:0] pin_edge_select [PINS];
  logic [3:0] oe_select [PINS];
  logic [31:0] reset_state;
  logic load_pending;

  logic [PINS-1:0] sync_a, sync_b, pin_state_read, next_pin_state, events;

  drive_if #(.PINS(PINS)) dif ();

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic pin_hit;
  logic [3:0] pin_idx;
  assign pin_hit = (addr_i[7:6] == `PIN_FORM_TAG) && (addr_i[5:2] < 4'(PINS));
  assign pin_idx = addr_i[5:2];

  function automatic logic wr_at(input logic [7:0] ofs);
    return wr_i && (addr_i == ofs);
  endfunction : wr_at

  // ---------------------------------------------------------------
  // configuration registers, both forms share the same bits except event_mask and oe_select, which only the port form reaches
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_pending <= 1'b1;
      port_output_value <= '0;
      for (int i = 0; i < PINS; i++) begin
        drive_mode_bits[i] <= `MODE_RESET;
      end
    end else begin
      load_pending <= 1'b0;
      if (load_pending) begin
        // reset flops take constants; the programmed state lands one cycle later
        for (int i = 0; i < PINS; i++) begin
          drive_mode_bits[i] <= reset_state[3*i +: 3];
          port_output_value[i] <= reset_state[24 + i];
        end
      end else begin
        for (int i = 0; i < PINS; i++) begin
          if (wr_at(`OFS_DRV_LOW)) begin
            drive_mode_bits[i][0] <= wdata_i[i];
          end
          if (wr_at(`OFS_DRV_MID)) begin
            drive_mode_bits[i][1] <= wdata_i[i];
          end
          if (wr_at(`OFS_DRV_HIGH)) begin
            drive_mode_bits[i][2] <= wdata_i[i];
          end
          if (wr_at(`OFS_OUT_VALUE)) begin
            port_output_value[i] <= wdata_i[i];
          end
          if (wr_i && pin_hit && (pin_idx == 4'(i))) begin
            drive_mode_bits[i] <= wdata_i[`PF_MODE_LSB +: 3];
            port_output_value[i] <= wdata_i[`PF_OUT];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      output_bypass_select <= '0;
      input_double_sync <= '0;
      slow_edge_select <= '0;
      bidir_enable <= '0;
      event_mask <= '0;
      for (int i = 0; i < PINS; i++) begin
        pin_edge_select[i] <= 2'h0;
        oe_select[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (wr_at(`OFS_BYPASS)) begin
          output_bypass_select[i] <= wdata_i[i];
        end
        if (wr_at(`OFS_DSYNC)) begin
          input_double_sync[i] <= wdata_i[i];
        end
        if (wr_at(`OFS_SLOW)) begin
          slow_edge_select[i] <= wdata_i[i];
        end
        if (wr_at(`OFS_BIDIR)) begin
          bidir_enable[i] <= wdata_i[i];
        end
        if (wr_at(`OFS_EVT_MASK)) begin
          event_mask[i] <= wdata_i[i];
        end
        if (wr_at(`OFS_EDGE_SEL)) begin
          pin_edge_select[i] <= wdata_i[2*i +: 2];
        end
        if (wr_at(`OFS_OE_SEL)) begin
          oe_select[i] <= wdata_i[4*i +: 4];
        end
        if (wr_i && pin_hit && (pin_idx == 4'(i))) begin
          output_bypass_select[i] <= wdata_i[`PF_BYP];
          slow_edge_select[i] <= wdata_i[`PF_SLOW];
          bidir_enable[i] <= wdata_i[`PF_BIDIR];
          input_double_sync[i] <= wdata_i[`PF_DSYNC];
          pin_edge_select[i] <= wdata_i[`PF_EDGE_LSB +: 2];
        end
      end
    end
  end

  // survives system reset, only power-on clears it
  always_ff @(posedge clk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      reset_state <= `RST_STATE_INIT;
    end else if (wr_at(`OFS_RST_STATE)) begin
      reset_state <= wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // drive path
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      dif.data[i] = output_bypass_select[i] ? sys_out_i[i] : port_output_value[i];
      dif.mode[i] = drive_mode_bits[i];
      if (bidir_enable[i] && !aux_oe_i[oe_select[i] % AUX_OE]) begin
        dif.mode[i] = MODE_HIZ_DIGITAL;
      end
    end
  end

  drive_decode #(
    .PINS(PINS)
  ) u_decode (
    .dif(dif)
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
      pin_res_o <= '0;
      pin_slow_o <= '0;
      pin_inbuf_en_o <= '0;
    end else begin
      pin_o <= dif.drv_val;
      pin_oe_o <= dif.drv_en;
      pin_res_o <= dif.res & dif.drv_en;
      // resistive drive has no slew control
      pin_slow_o <= slow_edge_select & dif.drv_en & ~dif.res;
      pin_inbuf_en_o <= dif.inbuf_en;
    end
  end

  // ---------------------------------------------------------------
  // input path and pin state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
    end
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      next_pin_state[i] = dif.inbuf_en[i] & (input_double_sync[i] ? sync_b[i] : pin_i[i]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_state_read <= '0;
      sys_in_o <= '0;
    end else begin
      pin_state_read <= next_pin_state;
      sys_in_o <= next_pin_state;
    end
  end

  // ---------------------------------------------------------------
  // edge events and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      case (pin_edge_select_e'(pin_edge_select[i]))
        EDGE_RISE: events[i] = next_pin_state[i] & ~pin_state_read[i];
        EDGE_FALL: events[i] = ~next_pin_state[i] & pin_state_read[i];
        EDGE_BOTH: events[i] = next_pin_state[i] ^ pin_state_read[i];
        default: events[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_event_flags <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (events[i]) begin
          pin_event_flags[i] <= 1'b1;
        end else if (wr_at(`OFS_EVT_FLAGS) && wdata_i[i]) begin
          pin_event_flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(pin_event_flags & event_mask);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (pin_hit) begin
      for (int i = 0; i < PINS; i++) begin
        if (pin_idx == 4'(i)) begin
          next_rdata[`PF_MODE_LSB +: 3] = drive_mode_bits[i];
          next_rdata[`PF_OUT] = port_output_value[i];
          next_rdata[`PF_BYP] = output_bypass_select[i];
          next_rdata[`PF_SLOW] = slow_edge_select[i];
          next_rdata[`PF_BIDIR] = bidir_enable[i];
          next_rdata[`PF_DSYNC] = input_double_sync[i];
          next_rdata[`PF_EDGE_LSB +: 2] = pin_edge_select[i];
        end
      end
    end else begin
      for (int i = 0; i < PINS; i++) begin
        case (addr_i)
          `OFS_OUT_VALUE: next_rdata[i] = port_output_value[i];
          `OFS_PIN_STATE: next_rdata[i] = pin_state_read[i];
          `OFS_DRV_LOW: next_rdata[i] = drive_mode_bits[i][0];
          `OFS_DRV_MID: next_rdata[i] = drive_mode_bits[i][1];
          `OFS_DRV_HIGH: next_rdata[i] = drive_mode_bits[i][2];
          `OFS_BYPASS: next_rdata[i] = output_bypass_select[i];
          `OFS_DSYNC: next_rdata[i] = input_double_sync[i];
          `OFS_SLOW: next_rdata[i] = slow_edge_select[i];
          `OFS_BIDIR: next_rdata[i] = bidir_enable[i];
          `OFS_EVT_FLAGS: next_rdata[i] = pin_event_flags[i];
          `OFS_EVT_MASK: next_rdata[i] = event_mask[i];
          `OFS_EDGE_SEL: next_rdata[2*i +: 2] = pin_edge_select[i];
          `OFS_OE_SEL: next_rdata[4*i +: 4] = oe_select[i];
          default: next_rdata[i] = 1'b0;
        endcase
      end
      if (addr_i == `OFS_RST_STATE) begin
        next_rdata = reset_state;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : port_pin_drive_control

//--- verification/port_pin_drive_control_chk.sv
// port-level checker of the port pin block
`timescale 1ns/100ps
module port_pin_drive_control_chk #(
  parameter int PINS = 8,
  parameter int AUX_OE = 16
) (
  // clock, resets and register port
  input logic clk_i, rst_b_i, por_b_i, wr_i, rd_i,
  input logic [7:0] addr_i,
  input logic [31:0] wdata_i, rdata_o,
  // pins and routed signals
  input logic [PINS-1:0] pin_i, pin_o, pin_oe_o, pin_res_o, pin_slow_o,
  input logic [PINS-1:0] pin_inbuf_en_o, sys_out_i, sys_in_o,
  input logic [AUX_OE-1:0] aux_oe_i,
  input logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // cycles since any cause of output change
  // ----------------------------------------
  logic [3:0] quiet;
  logic [PINS-1:0] pin_q, sys_q;
  logic [AUX_OE-1:0] aux_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quiet <= 4'h0;
      pin_q <= '0;
      sys_q <= '0;
      aux_q <= '0;
    end else begin
      pin_q <= pin_i;
      sys_q <= sys_out_i;
      aux_q <= aux_oe_i;
      if (wr_i || pin_i != pin_q || sys_out_i != sys_q || aux_oe_i != aux_q) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
  end
  a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property (rd_i && addr_i == 8'h3c |=> rdata_o == '0)
    else $error("unmapped read returned data");
  a_res_needs_oe: assert property ((pin_res_o & ~pin_oe_o) == '0)
    else $error("resistive flag without driver");
  a_slow_not_res: assert property ((pin_slow_o & pin_res_o) == '0)
    else $error("slow edge on resistive drive");
  a_sysin_gated: assert property ((sys_in_o & ~pin_inbuf_en_o) == '0)
    else $error("input passed with buffer off");
  a_drive_settles: assert property (quiet >= 4'h4 |-> $stable(pin_o) && $stable(pin_oe_o))
    else $error("drive changed with no cause");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> quiet < 4'h8)
    else $error("interrupt rose with no event");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("interrupt fell with no write");
endmodule : port_pin_drive_control_chk

bind port_pin_drive_control port_pin_drive_control_chk #(.PINS(PINS), .AUX_OE(AUX_OE)) u_chk (.*);

//--- verification/port_board.sv
// board model: external driver and loads on the port pins
`timescale 1ns/100ps
module port_board #(
  parameter int PINS = 8
) (
  input logic clk_i,
  input logic [PINS-1:0] pin_o, pin_oe_o, pin_res_o, ext_en_i, ext_val_i,
  output logic [PINS-1:0] pin_i
);
  // a floating pin must not settle to a convenient level
  logic [PINS-1:0] last = '0;
  logic [PINS-1:0] driven;
  assign driven = pin_oe_o | ext_en_i;
  // only driven levels are remembered, so an undriven pin holds still at the inverse
  always @(posedge clk_i) last <= (pin_i & driven) | (last & ~driven);
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pin_oe_o[i] && !pin_res_o[i]) pin_i[i] = pin_o[i];
      else if (ext_en_i[i]) pin_i[i] = ext_val_i[i];
      else if (pin_oe_o[i]) pin_i[i] = pin_o[i];
      else pin_i[i] = ~last[i];
    end
  end
endmodule : port_board

//--- verification/port_pin_drive_control_tb.sv
// self-checking bench of the port pin block
`timescale 1ns/100ps
module port_pin_drive_control_tb;
  logic clk_i = 1'b0, rst_b_i = 1'b0, por_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, irq_o;
  logic [7:0] addr_i = 8'h00, pin_i, pin_o, pin_oe_o, pin_res_o, pin_slow_o;
  logic [7:0] pin_inbuf_en_o, sys_in_o, sys_out_i = '0, ext_en = '0, ext_val = '0;
  logic [31:0] wdata_i = '0, rdata_o, rv;
  logic [15:0] aux_oe_i = '0;
  int err_count = 0, checked = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  port_pin_drive_control u_port_pin_drive_control (.*);
  port_board u_port_board (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_res_o(pin_res_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_i(pin_i));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  // {driver on, resistive, level} for a mode and data value
  function automatic logic [2:0] drv(input logic [2:0] m, input logic d);
    case (m)
      3'h2: return {1'b1, d, d};
      3'h3: return {1'b1, !d, d};
      3'h4: return {!d, 1'b0, d};
      3'h5: return {d, 1'b0, d};
      3'h6: return {2'b10, d};
      3'h7: return {2'b11, d};
      default: return {2'b00, d};
    endcase
  endfunction : drv
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("oe after reset", 32'(pin_oe_o), 32'h0);
    chk("inbuf after reset", 32'(pin_inbuf_en_o), 32'h0);
    wr(8'h60, 32'h0000_000e);
    rd(8'h60);
    chk("pin form beyond port", rv, 32'h0);
    rd(8'h3c);
    chk("unmapped read", rv, 32'h0);
    $display("done: reset");
  endtask : t_reset
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(8'h40, 32'({d[0], 3'(m)}));
        cyc(2);
        chk("pin0 drive", 32'({pin_oe_o[0], pin_res_o[0], pin_oe_o[0] ? pin_o[0] : d[0]}),
          32'(drv(3'(m), d[0])));
        chk("pin0 inbuf", 32'(pin_inbuf_en_o[0]), 32'(m != 0));
        rd(8'h08);
        chk("port form mode bit", 32'(rv[0]), 32'(m % 2));
      end
    end
    $display("done: modes");
  endtask : t_modes
  task automatic t_bypass();
    wr(8'h0c, 32'h2);
    wr(8'h10, 32'h2);
    @(posedge clk_i);
    sys_out_i <= 8'h02;
    wr(8'h14, 32'h2);
    cyc(2);
    chk("bypass high", 32'(pin_o[1]), 32'h1);
    @(posedge clk_i);
    sys_out_i <= 8'h00;
    cyc(2);
    chk("bypass low", 32'(pin_o[1]), 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h2);
    cyc(2);
    chk("output value drive", 32'(pin_o[1]), 32'h1);
    $display("done: bypass");
  endtask : t_bypass
  task automatic t_pin_state();
    wr(8'h08, 32'h4);
    @(posedge clk_i);
    ext_en <= 8'h1c;
    wr(8'h00, 32'ha5);
    cyc(4);
    rd(8'h04);
    chk("pin state", 32'(rv[2]), 32'h0);
    chk("input to routing", 32'(sys_in_o[2]), 32'h0);
    rd(8'h00);
    chk("output value kept", rv, 32'ha5);
    rd(8'h48);
    chk("pin form sees port form", rv, 32'h9);
    $display("done: pin state");
  endtask : t_pin_state
  task automatic t_edges();
    wr(8'h08, 32'hc);
    wr(8'h28, 32'h8);
    for (int e = 0; e < 4; e++) begin
      wr(8'h2c, 32'(e) << 6);
      cyc(6);
      wr(8'h24, 32'hff);
      @(posedge clk_i);
      ext_val[3] <= 1'b1;
      cyc(8);
      rd(8'h24);
      chk("rise flag", 32'(rv[3]), 32'(e % 2));
      chk("irq on rise", 32'(irq_o), 32'(e % 2));
      wr(8'h24, 32'h8);
      @(posedge clk_i);
      ext_val[3] <= 1'b0;
      cyc(8);
      rd(8'h24);
      chk("fall flag", 32'(rv[3]), 32'(e / 2));
    end
    wr(8'h28, 32'h0);
    wr(8'h24, 32'hff);
    @(posedge clk_i);
    ext_val[3] <= 1'b1;
    cyc(8);
    chk("masked irq", 32'(irq_o), 32'h0);
    wr(8'h28, 32'h8);
    cyc(3);
    chk("unmasked irq", 32'(irq_o), 32'h1);
    wr(8'h24, 32'h8);
    cyc(3);
    chk("cleared irq", 32'(irq_o), 32'h0);
    $display("done: edges");
  endtask : t_edges
  task automatic t_dsync();
    wr(8'h08, 32'h1c);
    for (int s = 0; s < 2; s++) begin
      wr(8'h18, 32'(s) << 4);
      cyc(5);
      @(posedge clk_i);
      ext_val[4] <= 1'(s == 0);
      repeat (2) @(posedge clk_i);
      // direct path already shows the new 1, two-flop path still the old 1
      #1 chk("input delay", 32'(sys_in_o[4]), 32'h1);
      cyc(3);
      chk("input settled", 32'(sys_in_o[4]), 32'(s == 0));
    end
    $display("done: dsync");
  endtask : t_dsync
  task automatic t_slow_bidir();
    wr(8'h54, 32'h2e);
    cyc(2);
    chk("slow strong", 32'(pin_slow_o[5]), 32'h1);
    rd(8'h1c);
    chk("slow port form", 32'(rv[5]), 32'h1);
    wr(8'h54, 32'h2f);
    cyc(2);
    chk("slow resistive", 32'(pin_slow_o[5]), 32'h0);
    wr(8'h30, 32'h0300_0000);
    @(posedge clk_i);
    aux_oe_i <= 16'h0008;
    wr(8'h58, 32'h4e);
    cyc(2);
    chk("bidir driving", 32'({pin_oe_o[6], pin_o[6]}), 32'h3);
    @(posedge clk_i);
    aux_oe_i <= 16'h0000;
    cyc(2);
    chk("bidir input", 32'({pin_oe_o[6], pin_inbuf_en_o[6]}), 32'h1);
    $display("done: slow bidir");
  endtask : t_slow_bidir
  task automatic t_reset_state();
    wr(8'h38, 32'h80c0_0000);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    cyc(3);
    chk("reset drivers", 32'(pin_oe_o), 32'h80);
    chk("reset level", 32'({pin_o[7], pin_res_o[7]}), 32'h2);
    rd(8'h38);
    chk("reset state kept", rv, 32'h80c0_0000);
    $display("done: reset state");
  endtask : t_reset_state
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    por_b_i <= 1'b1;
    cyc(2);
    t_reset();
    t_modes();
    t_bypass();
    t_pin_state();
    t_edges();
    t_dsync();
    t_slow_bidir();
    t_reset_state();
    report_and_stop();
  end
endmodule : port_pin_drive_control_tb
